/* File: rtl/branch_pkg.sv */
// Shared constants and carriers for the conditional branch execution block
package branch_pkg;

  localparam int PC_W = 21;
  localparam int OP_W = 16;
  localparam int OFS_W = 8;
  localparam int QPH_W = 2;

  // Upper-byte opcodes of the three conditional branches
  localparam logic [7:0] OPC_CARRY_CLEAR = 8'he3;
  localparam logic [7:0] OPC_POSITIVE = 8'he7;
  localparam logic [7:0] OPC_NO_OVERFLOW = 8'he5;

  // Opcode field positions
  localparam int OPC_HI = 15;
  localparam int OPC_LO = 8;
  localparam int OFS_HI = 7;
  localparam int OFS_LO = 0;

  // Quarter phase codes
  localparam logic [QPH_W-1:0] PH_Q1 = 2'h0;
  localparam logic [QPH_W-1:0] PH_Q2 = 2'h1;
  localparam logic [QPH_W-1:0] PH_Q3 = 2'h2;
  localparam logic [QPH_W-1:0] PH_Q4 = 2'h3;

  // Bytes per program word, and reset address
  localparam logic [PC_W-1:0] WORD_BYTES = 21'h000002;
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;

  typedef enum logic [1:0] {
    BR_NONE,
    BR_CARRY_CLEAR,
    BR_POSITIVE,
    BR_NO_OVERFLOW
  } branch_kind_e;

  // Arithmetic flags tested by the branches
  typedef struct packed {
    logic negative;
    logic overflow;
    logic carry;
  } flags_s;

  // Fetched instruction with its valid mark
  typedef struct packed {
    logic valid;
    logic [OP_W-1:0] word;
  } fetch_s;

  typedef enum logic [1:0] {
    EX_RUN,
    EX_IDLE
  } exec_state_e;

endpackage

/* File: rtl/quarter_phase.sv */
// Quarter phase generator: four clk_sys cycles per instruction cycle
`timescale 1ns/1ps
module quarter_phase (
  input wire logic clk_sys,
  input wire logic rst,
  output logic [branch_pkg::QPH_W-1:0] phase,
  output logic cycle_end
);
  import branch_pkg::*;

  logic [QPH_W-1:0] phase_reg;
  logic [QPH_W-1:0] phase_next;

  // Free-running phase counter, wraps Q4 back to Q1
  always_comb begin
    phase_next = phase_reg + 2'h1;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phase_reg <= PH_Q1;
    end else begin
      phase_reg <= phase_next;
    end
  end

  assign phase = phase_reg;
  assign cycle_end = (phase_reg == PH_Q4);
endmodule // quarter_phase

/* File: rtl/conditional_branch_exec.sv */
// Conditional relative branch execution for an 8-bit core
// Summary of operation
// - Decode upper byte e7 as branch if positive
// - Branch if positive taken when negative clear
// - Taken: counter plus twice signed offset
// - Branches never change any status flag
// - One cycle untaken, two cycles taken
// - Taken: Q4 writes counter, then idle cycle
// - Untaken: Q4 idle, counter just advances
// - Decode e5, branch when overflow clear
// - Decode e3, branch when carry clear
`timescale 1ns/1ps
module conditional_branch_exec (
  input wire logic clk_sys,
  input wire logic rst,
  input wire branch_pkg::fetch_s fetch_in,
  input wire branch_pkg::flags_s flags_in,
  output branch_pkg::flags_s flags_out,
  output logic [branch_pkg::PC_W-1:0] program_counter,
  output logic fetch_take,
  output logic pc_write,
  output logic branch_taken,
  output logic exec_idle,
  output logic [branch_pkg::QPH_W-1:0] q_phase
);
  import branch_pkg::*;

  logic [QPH_W-1:0] phase;
  logic cycle_end;

  // Recognise which conditional branch an opcode holds
  function automatic branch_kind_e decode_kind(input logic [OP_W-1:0] op);
    logic [7:0] hi;
    hi = op[OPC_HI:OPC_LO];
    if (hi == OPC_POSITIVE) begin
      decode_kind = BR_POSITIVE;
    end else if (hi == OPC_NO_OVERFLOW) begin
      decode_kind = BR_NO_OVERFLOW;
    end else if (hi == OPC_CARRY_CLEAR) begin
      decode_kind = BR_CARRY_CLEAR;
    end else begin
      decode_kind = BR_NONE;
    end
  endfunction

  // Condition test: each branch wants its flag clear
  function automatic logic cond_met(input branch_kind_e k, input flags_s f);
    unique case (k)
      BR_POSITIVE: cond_met = !f.negative;
      BR_NO_OVERFLOW: cond_met = !f.overflow;
      BR_CARRY_CLEAR: cond_met = !f.carry;
      BR_NONE: cond_met = 1'b0;
    endcase
  endfunction

  // Relative target: the sign is replicated to full width before doubling,
  // so a backward jump wraps the counter instead of losing its sign bit
  function automatic logic [PC_W-1:0] branch_target(input logic [PC_W-1:0] base,
    input logic [OFS_W-1:0] ofs);
    logic [PC_W-1:0] wide;
    wide = {{(PC_W-OFS_W){ofs[OFS_W-1]}}, ofs};
    branch_target = base + (wide << 1);
  endfunction

  // Quarter phase source; its Q4 marker closes each instruction cycle
  quarter_phase u_phase (
    .clk_sys(clk_sys),
    .rst(rst),
    .phase(phase),
    .cycle_end(cycle_end)
  );

  // Execution state and latched decode
  exec_state_e state_reg, state_next;
  logic [PC_W-1:0] pc_reg, pc_next;
  branch_kind_e kind_reg, kind_next;
  logic [OFS_W-1:0] ofs_reg, ofs_next;
  logic [PC_W-1:0] target_reg, target_next;
  logic cond_reg, cond_next;

  // One-clock pulses and status levels seen outside
  logic take_reg, take_next;
  logic wr_reg, wr_next;
  logic taken_reg, taken_next;
  logic idle_reg, idle_next;

  // Observation copies: phase and flags, one clock behind
  logic [QPH_W-1:0] qph_reg, qph_next;
  flags_s flags_reg, flags_next;

  // Per-phase sequencing of one instruction cycle
  always_comb begin
    state_next = state_reg;
    pc_next = pc_reg;
    kind_next = kind_reg;
    ofs_next = ofs_reg;
    target_next = target_reg;
    cond_next = cond_reg;
    unique case (state_reg)
      EX_RUN: begin
        if (phase == PH_Q1) begin
          // Decode; the counter is advanced past this word in this phase
          kind_next = fetch_in.valid ? decode_kind(fetch_in.word) : BR_NONE;
          pc_next = pc_reg + WORD_BYTES;
        end else if (phase == PH_Q2) begin
          // Only the low byte of the word carries the offset
          ofs_next = fetch_in.word[OFS_HI:OFS_LO];
        end else if (phase == PH_Q3) begin
          // Sign-extend and double the offset, range -128..127 words
          target_next = branch_target(pc_reg, ofs_reg);
          cond_next = cond_met(kind_reg, flags_in);
        end else if (cond_reg) begin
          // Q4 of a taken branch: load the target, then one idle cycle
          pc_next = target_reg;
          state_next = EX_IDLE;
        end
      end
      EX_IDLE: begin
        // Idle cycle: the sequential prefetch is dropped unused
        if (cycle_end) begin
          state_next = EX_RUN;
          cond_next = 1'b0;
        end
      end
      default: begin
        // Unused state code: fall back to running so the core cannot stall
        state_next = EX_RUN;
      end
    endcase
  end

  // Sequencing registers; reset puts the counter at the reset address
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= EX_RUN;
      pc_reg <= PC_RESET;
      kind_reg <= BR_NONE;
      ofs_reg <= '0;
      target_reg <= PC_RESET;
      cond_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pc_reg <= pc_next;
      kind_reg <= kind_next;
      ofs_reg <= ofs_next;
      target_reg <= target_next;
      cond_reg <= cond_next;
    end
  end

  // Pulses seen outside: each is registered, so a consumer gets it one clock
  // after the phase that raised it, and an untaken Q4 writes nothing
  always_comb begin
    take_next = 1'b0;
    wr_next = 1'b0;
    taken_next = taken_reg;
    idle_next = (state_reg == EX_IDLE);
    unique case (state_reg)
      EX_RUN: begin
        if (phase == PH_Q1) begin
          taken_next = 1'b0;
        end else if (phase == PH_Q4) begin
          wr_next = cond_reg;
          taken_next = cond_reg;
          take_next = !cond_reg;
        end
      end
      EX_IDLE: begin
        // Next fetch is consumed only when the idle cycle closes
        take_next = cycle_end;
      end
      default: begin
        take_next = 1'b0;
      end
    endcase
  end

  // Pulse registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      take_reg <= 1'b0;
      wr_reg <= 1'b0;
      taken_reg <= 1'b0;
      idle_reg <= 1'b0;
    end else begin
      take_reg <= take_next;
      wr_reg <= wr_next;
      taken_reg <= taken_next;
      idle_reg <= idle_next;
    end
  end

  // Observation copies follow their sources one clock late; the flags are
  // only carried, never written, since no branch may alter them
  always_comb begin
    qph_next = phase;
    flags_next = flags_in; // Passed through untouched
  end

  // Observation registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      qph_reg <= PH_Q1;
      flags_reg <= '0;
    end else begin
      qph_reg <= qph_next;
      flags_reg <= flags_next;
    end
  end

  // Registered outputs
  assign flags_out = flags_reg;
  assign program_counter = pc_reg;
  assign fetch_take = take_reg;
  assign pc_write = wr_reg;
  assign branch_taken = taken_reg;
  assign exec_idle = idle_reg;
  assign q_phase = qph_reg;
endmodule // conditional_branch_exec

/* File: verif/conditional_branch_exec_assertions.sv */
// Port checker for the conditional branch block
`timescale 1ns/1ps
module conditional_branch_exec_assertions (
  input wire logic clk_sys,
  input wire logic rst,
  input wire branch_pkg::fetch_s fetch_in,
  input wire branch_pkg::flags_s flags_in,
  input wire branch_pkg::flags_s flags_out,
  input wire logic [branch_pkg::PC_W-1:0] program_counter,
  input wire logic fetch_take,
  input wire logic pc_write,
  input wire logic branch_taken,
  input wire logic exec_idle,
  input wire logic [branch_pkg::QPH_W-1:0] q_phase
);
  import branch_pkg::*;
  logic [PC_W-1:0] step;
  // Doubled signed offset; the fetch word is held through the cycle
  assign step = {{12{fetch_in.word[7]}}, fetch_in.word[7:0], 1'b0};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence idle_s; exec_idle [*4]; endsequence
  sequence quiet_s; !pc_write [*7]; endsequence
  flags_pass_a: assert property (!$past(rst) |-> flags_out == $past(flags_in))
    else $error("flags changed");
  pc_target_a: assert property (pc_write && !$past(rst) |->
    program_counter == $past(program_counter) + $past(step)) else $error("bad target");
  pc_advance_a: assert property (!$past(rst) && !pc_write &&
    program_counter != $past(program_counter) |-> program_counter == $past(program_counter) + 21'h2)
    else $error("bad advance");
  write_flag_a: assert property (pc_write |-> branch_taken) else $error("no taken flag");
  write_gap_a: assert property (pc_write |=> quiet_s) else $error("writes too close");
  idle_cycle_a: assert property (pc_write |=> idle_s) else $error("no idle cycle");
  taken_end_a: assert property (pc_write |-> ##4 fetch_take) else $error("late end");
  take_gap_a: assert property (fetch_take |=> !fetch_take [*3]) else $error("short cycle");
  idle_quiet_a: assert property (exec_idle |-> !pc_write) else $error("idle write");
  take_phase_a: assert property (fetch_take |-> q_phase == PH_Q4)
    else $error("fetch end off the last phase");
  write_phase_a: assert property (pc_write |-> q_phase == PH_Q4)
    else $error("counter write off the last phase");
  phase_step_a: assert property (!$past(rst) && !$past(rst, 2) |->
    q_phase == $past(q_phase) + 2'h1) else $error("phase skipped");
endmodule // conditional_branch_exec_assertions
bind conditional_branch_exec conditional_branch_exec_assertions chk_u (.clk_sys(clk_sys),
  .rst(rst), .fetch_in(fetch_in), .flags_in(flags_in), .flags_out(flags_out),
  .program_counter(program_counter), .fetch_take(fetch_take), .pc_write(pc_write),
  .branch_taken(branch_taken), .exec_idle(exec_idle), .q_phase(q_phase));

/* File: verif/conditional_branch_exec_bench.sv */
// Self-checking bench for the conditional branch block
`timescale 1ns/1ps
module conditional_branch_exec_bench;
  import branch_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  fetch_s fetch_in = '0;
  flags_s flags_in = '0;
  flags_s flags_out;
  logic [PC_W-1:0] program_counter;
  logic [PC_W-1:0] pc_model = '0;
  logic pc_write;
  logic fetch_take;
  logic branch_taken;
  logic exec_idle;
  logic [QPH_W-1:0] q_phase;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #5 clk_sys = ~clk_sys;
  conditional_branch_exec dut_u (.clk_sys(clk_sys), .rst(rst), .fetch_in(fetch_in),
    .flags_in(flags_in), .flags_out(flags_out), .program_counter(program_counter),
    .fetch_take(fetch_take), .pc_write(pc_write), .branch_taken(branch_taken),
    .exec_idle(exec_idle), .q_phase(q_phase));
  task automatic check(string what, logic [PC_W-1:0] seen, logic [PC_W-1:0] want);
    samples_checked++;
    if (seen !== want) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, want, seen);
    end
  endtask
  // Branch decision from opcode and the one flag it tests
  function automatic logic taken_of(logic v, logic [7:0] op, flags_s g);
    return v && ((op == 8'he3 && !g.carry) || (op == 8'he5 && !g.overflow) ||
      (op == 8'he7 && !g.negative));
  endfunction
  // One instruction cycle, two when taken; junk is fed in the idle cycle
  task automatic run(logic [15:0] w, logic v, flags_s g);
    logic [PC_W-1:0] writes;
    logic [PC_W-1:0] takes;
    logic tk;
    writes = '0;
    takes = '0;
    tk = taken_of(v, w[15:8], g);
    fetch_in = {v, w};
    flags_in = g;
    for (int i = 0; i < (tk ? 8 : 4); i++) begin
      @(negedge clk_sys);
      writes += PC_W'(pc_write);
      takes += PC_W'(fetch_take);
      if (tk && i == 3) fetch_in = {1'b1, 8'he3 + 8'(2 * $urandom_range(0, 2)), 8'($urandom)};
    end
    pc_model = pc_model + 21'h2 + (tk ? {{12{w[7]}}, w[7:0], 1'b0} : 21'h0);
    check("pc", program_counter, pc_model);
    check("writes", writes, PC_W'(tk));
    check("fetch ends", takes, 21'h1);
    check("taken", PC_W'(branch_taken), PC_W'(tk));
    check("idle", PC_W'(exec_idle), PC_W'(tk));
    check("phase", PC_W'(q_phase), PC_W'(PH_Q4));
    check("flags", PC_W'(flags_out), PC_W'(g));
  endtask
  task automatic end_sim();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Ceiling well above the longest sequence of taken branches
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      end_sim();
    end
  end
  // Corners first: offset extremes, each flag both ways, foreign and invalid words
  initial begin
    void'($urandom(32'he4ab));
    repeat (20) @(negedge clk_sys);
    check("reset pc", program_counter, 21'h0);
    rst = 1'b0;
    run(16'he780, 1'b1, 3'b000);
    run(16'he77f, 1'b1, 3'b100);
    run(16'he5ff, 1'b1, 3'b000);
    run(16'he501, 1'b1, 3'b010);
    run(16'he380, 1'b1, 3'b110);
    run(16'he37f, 1'b1, 3'b001);
    run(16'he67f, 1'b1, 3'b000);
    run(16'he77f, 1'b0, 3'b000);
    repeat (300) run({8'he1 + 8'(2 * $urandom_range(0, 3)), 8'($urandom)},
      $urandom_range(0, 7) != 0, 3'($urandom));
    end_sim();
  end
endmodule // conditional_branch_exec_bench
